// ==== hw/term_vref_pkg.sv ====
// Constants, carriers and helpers for the termination and reference mode registers
package term_vref_pkg;

  // ------------------------------------------------------------
  // Addresses and fields
  // ------------------------------------------------------------
  localparam logic [5:0] ODT_CONTROL_ADDR = 6'h0B;
  localparam logic [5:0] CA_REFERENCE_LEVEL_ADDR = 6'h0C;
  localparam int DATA_TERM_LSB = 0;
  localparam int CMD_TERM_LSB = 4;
  localparam int REF_CODE_LSB = 0;
  localparam int REF_RANGE_BIT = 6;
  localparam logic [2:0] TERM_DISABLED = 3'h0;
  localparam logic [2:0] TERM_RESERVED = 3'h7;
  localparam logic [5:0] REF_CODE_MAX = 6'h32;
  localparam logic [5:0] REF_CODE_DEF_STD = 6'h0D;
  localparam logic [5:0] REF_CODE_DEF_RED = 6'h1D;
  localparam logic REF_RANGE_DEF = 1'b1;
  localparam int READ_DQ_WIDTH = 16;

  // Levels in tenths of a percent of the I/O supply
  localparam logic [9:0] STD_BASE_R0 = 10'h064;
  localparam logic [9:0] STD_BASE_R1 = 10'h0DC;
  localparam logic [9:0] STD_STEP = 10'h004;
  localparam logic [9:0] RED_BASE_R0 = 10'h096;
  localparam logic [9:0] RED_BASE_R1 = 10'h149;
  localparam logic [9:0] RED_STEP_X10 = 10'h03C;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic       write;
    logic [5:0] addr;
    logic [7:0] op;
  } mode_cmd_t;

  typedef struct packed {
    logic [2:0] data_term;
    logic [2:0] cmd_term;
    logic [5:0] ref_code;
    logic       ref_range;
  } setpoint_t;

  // Code to level map, shared by every reference register
  function automatic logic [9:0] ref_level_tenths(input logic [5:0] code, input logic range,
                                                  input logic reduced);
    logic [15:0] scaled;
    scaled = 16'({10'h000, code} * {6'h00, RED_STEP_X10}) + 16'h0005;
    if (reduced) begin
      ref_level_tenths = (range ? RED_BASE_R1 : RED_BASE_R0) + 10'(scaled / 16'h000A);
    end else begin
      ref_level_tenths = (range ? STD_BASE_R1 : STD_BASE_R0) + 10'({4'h0, code} * STD_STEP);
    end
  endfunction

endpackage

// ==== hw/term_vref_regs.sv ====
// Termination and command-bus reference mode registers with set-point copies
`timescale 1ns/1ps
module term_vref_regs #(
  parameter bit REDUCED_VOLT = 1'b0
) (
  input wire logic clk, // Core clock
  input wire logic rst_n, // Power-on or reset, active low
  input wire logic link_clk, // Command link clock
  input wire logic cmd_valid, // Mode command strobe, link clock
  input wire logic cmd_write, // 1 write, 0 read
  input wire logic [5:0] cmd_addr, // Mode register address
  input wire logic [7:0] cmd_op, // Write operand
  output logic cmd_busy, // Command in progress, link clock
  output logic rd_valid, // Read data strobe, link clock
  output logic [15:0] rd_dq, // Read data lines
  input wire logic setpoint_access_select, // Copy reached by commands
  input wire logic setpoint_active_select, // Copy that drives operation
  input wire logic calib_pin_to_supply, // Calibration strap pin
  input wire logic calib_cmd, // Calibration command pulse
  input wire logic calib_default_reset, // Restore default calibration pulse
  output logic calib_start, // Accepted calibration pulse
  output logic calib_use_default, // Default calibration in use
  output logic [2:0] data_termination_code, // Active data termination
  output logic [2:0] cmd_termination_code, // Active command termination
  output logic [5:0] ca_ref_level_code, // Active reference code
  output logic ca_ref_range, // Active reference range
  output logic [9:0] ca_ref_tenths // Active level, 0.1% of supply
);

  // ------------------------------------------------------------
  // Field decoding
  // ------------------------------------------------------------
  // Reserved termination code keeps the stored field
  function automatic logic [2:0] term_merge(input logic [2:0] stored, input logic [2:0] written);
    logic [2:0] merged;
    merged = written;
    if (written == term_vref_pkg::TERM_RESERVED) begin
      merged = stored;
    end
    return merged;
  endfunction

  // Reserved reference code keeps the stored field
  function automatic logic [5:0] code_merge(input logic [5:0] stored, input logic [5:0] written);
    logic [5:0] merged;
    merged = written;
    if (written > term_vref_pkg::REF_CODE_MAX) begin
      merged = stored;
    end
    return merged;
  endfunction

  // Read image of one copy, bit 7 always zero
  function automatic logic [7:0] ref_image(input term_vref_pkg::setpoint_t sp);
    return {1'b0, sp.ref_range, sp.ref_code};
  endfunction

  // ------------------------------------------------------------
  // Link domain reset
  // ------------------------------------------------------------
  // Lags rst_n by two link cycles on entry and on release
  logic lrst_s1_ff, lrst_s2_ff;

  always_ff @(posedge link_clk) begin
    lrst_s1_ff <= rst_n;
    lrst_s2_ff <= lrst_s1_ff;
  end

  // ------------------------------------------------------------
  // Link side command capture
  // ------------------------------------------------------------
  term_vref_pkg::mode_cmd_t link_cmd;
  logic accept;
  logic xfer_busy;
  logic ret_valid;
  logic [7:0] ret_data;
  logic lbusy_ff, nxt_lbusy;
  logic rpend_ff, nxt_rpend;
  logic rv_ff, nxt_rv;
  logic [15:0] rdq_ff, nxt_rdq;

  always_comb begin
    link_cmd.write = cmd_write;
    link_cmd.addr = cmd_addr;
    link_cmd.op = cmd_op;
    accept = cmd_valid & ~lbusy_ff;
    nxt_rpend = (rpend_ff & ~ret_valid) | (accept & ~cmd_write);
    nxt_lbusy = accept | (lbusy_ff & (xfer_busy | nxt_rpend));
    nxt_rv = ret_valid;
    nxt_rdq = rdq_ff;
    if (ret_valid) begin
      nxt_rdq = {8'h00, ret_data};
    end
  end

  always_ff @(posedge link_clk) begin
    if (!lrst_s2_ff) begin
      lbusy_ff <= 1'b0;
      rpend_ff <= 1'b0;
      rv_ff <= 1'b0;
      rdq_ff <= 16'h0000;
    end else begin
      lbusy_ff <= nxt_lbusy;
      rpend_ff <= nxt_rpend;
      rv_ff <= nxt_rv;
      rdq_ff <= nxt_rdq;
    end
  end

  assign cmd_busy = lbusy_ff;
  assign rd_valid = rv_ff;
  assign rd_dq = rdq_ff;

  // ------------------------------------------------------------
  // Crossings
  // ------------------------------------------------------------
  logic core_cmd_valid;
  term_vref_pkg::mode_cmd_t core_cmd;
  logic ret_launch;
  logic [7:0] ret_word_ff, nxt_ret_word;
  logic ret_launch_ff, nxt_ret_launch;

  // Carried word is held until acknowledged, so it is stable when sampled
  word_handshake #(
    .WIDTH($bits(term_vref_pkg::mode_cmd_t))
  ) u_cmd_xfer (
    .src_clk(link_clk),
    .src_rst_n(lrst_s2_ff),
    .src_valid(accept),
    .src_data(link_cmd),
    .src_busy(xfer_busy),
    .dst_clk(clk),
    .dst_rst_n(rst_n),
    .dst_valid(core_cmd_valid),
    .dst_data(core_cmd)
  );

  // No busy check on return: one command is in flight at a time
  word_handshake #(
    .WIDTH(8)
  ) u_ret_xfer (
    .src_clk(clk),
    .src_rst_n(rst_n),
    .src_valid(ret_launch),
    .src_data(ret_word_ff),
    .src_busy(),
    .dst_clk(link_clk),
    .dst_rst_n(lrst_s2_ff),
    .dst_valid(ret_valid),
    .dst_data(ret_data)
  );

  assign ret_launch = ret_launch_ff;

  // ------------------------------------------------------------
  // Set-point storage
  // ------------------------------------------------------------
  localparam logic [5:0] REF_DEF =
    REDUCED_VOLT ? term_vref_pkg::REF_CODE_DEF_RED : term_vref_pkg::REF_CODE_DEF_STD;
  localparam term_vref_pkg::setpoint_t SP_RESET = '{
    data_term: term_vref_pkg::TERM_DISABLED,
    cmd_term: term_vref_pkg::TERM_DISABLED,
    ref_code: REF_DEF,
    ref_range: term_vref_pkg::REF_RANGE_DEF
  };

  // Defaults and read width must be ones the logic can hold
  initial begin
    if (REF_DEF > term_vref_pkg::REF_CODE_MAX) $error("default reference code is reserved");
    if (term_vref_pkg::READ_DQ_WIDTH != 16) $error("read data width must be 16");
  end

  term_vref_pkg::setpoint_t sp_ff [2];
  term_vref_pkg::setpoint_t nxt_sp [2];
  term_vref_pkg::setpoint_t acc_sp;
  logic [2:0] wr_data_term, wr_cmd_term;
  logic [5:0] wr_ref_code;
  logic [7:0] rd_word;

  always_comb begin
    nxt_sp = sp_ff;
    acc_sp = sp_ff[setpoint_access_select];
    wr_data_term = core_cmd.op[term_vref_pkg::DATA_TERM_LSB +: 3];
    wr_cmd_term = core_cmd.op[term_vref_pkg::CMD_TERM_LSB +: 3];
    wr_ref_code = core_cmd.op[term_vref_pkg::REF_CODE_LSB +: 6];
    if (core_cmd_valid && core_cmd.write) begin
      case (core_cmd.addr)
        term_vref_pkg::ODT_CONTROL_ADDR: begin
          acc_sp.data_term = term_merge(acc_sp.data_term, wr_data_term);
          acc_sp.cmd_term = term_merge(acc_sp.cmd_term, wr_cmd_term);
          nxt_sp[setpoint_access_select] = acc_sp;
        end
        term_vref_pkg::CA_REFERENCE_LEVEL_ADDR: begin
          acc_sp.ref_code = code_merge(acc_sp.ref_code, wr_ref_code);
          acc_sp.ref_range = core_cmd.op[term_vref_pkg::REF_RANGE_BIT];
          nxt_sp[setpoint_access_select] = acc_sp;
        end
        default: begin
          // Writes to other registers leave both copies alone
          nxt_sp = sp_ff;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sp_ff[0] <= SP_RESET;
      sp_ff[1] <= SP_RESET;
    end else begin
      sp_ff <= nxt_sp;
    end
  end

  // ------------------------------------------------------------
  // Read return
  // ------------------------------------------------------------
  always_comb begin
    rd_word = 8'h00;
    case (core_cmd.addr)
      term_vref_pkg::CA_REFERENCE_LEVEL_ADDR: begin
        rd_word = ref_image(sp_ff[setpoint_access_select]);
      end
      default: begin
        // Write-only and absent registers read as zero
        rd_word = 8'h00;
      end
    endcase
    nxt_ret_launch = core_cmd_valid & ~core_cmd.write;
    nxt_ret_word = nxt_ret_launch ? rd_word : ret_word_ff;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ret_launch_ff <= 1'b0;
      ret_word_ff <= 8'h00;
    end else begin
      ret_launch_ff <= nxt_ret_launch;
      ret_word_ff <= nxt_ret_word;
    end
  end

  // ------------------------------------------------------------
  // Operating settings from the active copy
  // ------------------------------------------------------------
  // One cycle behind a select or copy change
  term_vref_pkg::setpoint_t act_sp;
  logic [2:0] dterm_ff, nxt_dterm;
  logic [2:0] cterm_ff, nxt_cterm;
  logic [5:0] rcode_ff, nxt_rcode;
  logic rrange_ff, nxt_rrange;
  logic [9:0] tenths_ff, nxt_tenths;

  always_comb begin
    act_sp = sp_ff[setpoint_active_select];
    nxt_dterm = act_sp.data_term;
    nxt_cterm = act_sp.cmd_term;
    nxt_rcode = act_sp.ref_code;
    nxt_rrange = act_sp.ref_range;
    nxt_tenths = term_vref_pkg::ref_level_tenths(act_sp.ref_code, act_sp.ref_range,
                                                 REDUCED_VOLT);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dterm_ff <= term_vref_pkg::TERM_DISABLED;
      cterm_ff <= term_vref_pkg::TERM_DISABLED;
      rcode_ff <= REF_DEF;
      rrange_ff <= term_vref_pkg::REF_RANGE_DEF;
      tenths_ff <= 10'h000;
    end else begin
      dterm_ff <= nxt_dterm;
      cterm_ff <= nxt_cterm;
      rcode_ff <= nxt_rcode;
      rrange_ff <= nxt_rrange;
      tenths_ff <= nxt_tenths;
    end
  end

  assign data_termination_code = dterm_ff;
  assign cmd_termination_code = cterm_ff;
  assign ca_ref_level_code = rcode_ff;
  assign ca_ref_range = rrange_ff;
  assign ca_ref_tenths = tenths_ff;

  // ------------------------------------------------------------
  // Calibration strap
  // ------------------------------------------------------------
  // Strap is static after power-up, so it is caught once after reset
  logic strap_s1_ff;
  logic strap_s2_ff;
  logic strap_taken_ff, nxt_strap_taken;
  logic strap_supply_ff, nxt_strap_supply;

  // Synchroniser runs through reset so the pin is settled at release
  always_ff @(posedge clk) begin
    strap_s1_ff <= calib_pin_to_supply;
    strap_s2_ff <= strap_s1_ff;
  end

  always_comb begin
    nxt_strap_taken = 1'b1;
    nxt_strap_supply = strap_taken_ff ? strap_supply_ff : strap_s2_ff;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      strap_taken_ff <= 1'b0;
      strap_supply_ff <= 1'b0;
    end else begin
      strap_taken_ff <= nxt_strap_taken;
      strap_supply_ff <= nxt_strap_supply;
    end
  end

  // ------------------------------------------------------------
  // Calibration commands
  // ------------------------------------------------------------
  logic cal_start_ff, nxt_cal_start;
  logic cal_def_ff, nxt_cal_def;

  always_comb begin
    nxt_cal_start = strap_taken_ff & strap_supply_ff & calib_cmd;
    nxt_cal_def = cal_def_ff;
    // Grounded strap pins default; a default reset beats a command
    if (!strap_taken_ff || !strap_supply_ff) begin
      nxt_cal_def = 1'b1;
    end else if (calib_default_reset) begin
      nxt_cal_def = 1'b1;
    end else if (calib_cmd) begin
      nxt_cal_def = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cal_start_ff <= 1'b0;
      cal_def_ff <= 1'b1;
    end else begin
      cal_start_ff <= nxt_cal_start;
      cal_def_ff <= nxt_cal_def;
    end
  end

  assign calib_start = cal_start_ff;
  assign calib_use_default = cal_def_ff;

endmodule

// ==== hw/word_handshake.sv ====
// Toggle handshake that carries one word between two clock domains
`timescale 1ns/1ps
module word_handshake #(
  parameter int WIDTH = 8
) (
  input wire logic src_clk, // Source clock
  input wire logic src_rst_n, // Source reset, synchronous
  input wire logic src_valid, // Launch word, ignored while busy
  input wire logic [WIDTH-1:0] src_data, // Word to carry
  output logic src_busy, // Word in flight
  input wire logic dst_clk, // Destination clock
  input wire logic dst_rst_n, // Destination reset, synchronous
  output logic dst_valid, // One-cycle word strobe
  output logic [WIDTH-1:0] dst_data // Carried word
);

  initial begin
    if (WIDTH < 1) $error("WIDTH must be positive");
  end

  // ------------------------------------------------------------
  // Source side
  // ------------------------------------------------------------
  logic req_ff, nxt_req, busy_ff, nxt_busy;
  logic [WIDTH-1:0] hold_ff, nxt_hold;
  logic ack_s1_ff, ack_s2_ff, ack_ff;

  always_comb begin
    nxt_req = req_ff ^ (src_valid & ~busy_ff);
    nxt_hold = (src_valid & ~busy_ff) ? src_data : hold_ff;
    nxt_busy = nxt_req != ack_s2_ff;
  end

  always_ff @(posedge src_clk) begin
    if (!src_rst_n) begin
      req_ff <= 1'b0;
      busy_ff <= 1'b0;
      hold_ff <= '0;
      ack_s1_ff <= 1'b0;
      ack_s2_ff <= 1'b0;
    end else begin
      req_ff <= nxt_req;
      busy_ff <= nxt_busy;
      hold_ff <= nxt_hold;
      ack_s1_ff <= ack_ff;
      ack_s2_ff <= ack_s1_ff;
    end
  end

  assign src_busy = busy_ff;

  // ------------------------------------------------------------
  // Destination side
  // ------------------------------------------------------------
  logic req_s1_ff, req_s2_ff, req_s3_ff;
  logic dv_ff, nxt_dv;
  logic [WIDTH-1:0] dd_ff, nxt_dd;

  always_comb begin
    nxt_dv = req_s2_ff ^ req_s3_ff;
    nxt_dd = nxt_dv ? hold_ff : dd_ff;
  end

  always_ff @(posedge dst_clk) begin
    if (!dst_rst_n) begin
      req_s1_ff <= 1'b0;
      req_s2_ff <= 1'b0;
      req_s3_ff <= 1'b0;
      ack_ff <= 1'b0;
      dv_ff <= 1'b0;
      dd_ff <= '0;
    end else begin
      req_s1_ff <= req_ff;
      req_s2_ff <= req_s1_ff;
      req_s3_ff <= req_s2_ff;
      ack_ff <= req_s3_ff;
      dv_ff <= nxt_dv;
      dd_ff <= nxt_dd;
    end
  end

  assign dst_valid = dv_ff;
  assign dst_data = dd_ff;

endmodule

// ==== tb/mode_ctrl_model.sv ====
// Controller model issuing mode writes and reads on the link
`timescale 1ns/1ps
module mode_ctrl_model (
  input wire logic link_clk, // Link clock
  input wire logic cmd_busy, // Busy
  input wire logic rd_valid, // Read strobe
  input wire logic [15:0] rd_dq, // Read data
  output logic cmd_valid, // Strobe
  output logic cmd_write, // Write or read
  output logic [5:0] cmd_addr, // Address
  output logic [7:0] cmd_op, // Operand
  output logic tmo // Wait ran out
);
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_addr = 6'h3F;
    cmd_op = 8'h00;
    tmo = 1'b0;
  end
  // Whole byte sent, range always with code
  task automatic issue(input logic w, input logic [5:0] a, input logic [7:0] op, output logic [15:0] d);
    int n;
    n = 0;
    d = 16'h0000;
    @(negedge link_clk);
    while (cmd_busy && n < 40) begin
      @(negedge link_clk);
      n++;
    end
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_addr = a;
    cmd_op = op;
    @(negedge link_clk);
    cmd_valid = 1'b0;
    cmd_write = ~w;
    cmd_addr = ~a;
    cmd_op = ~op;
    @(negedge link_clk);
    while ((w ? cmd_busy : !rd_valid) && n < 40) begin
      @(negedge link_clk);
      n++;
    end
    d = rd_dq;
    tmo = tmo | (n >= 40);
  endtask
endmodule

// ==== tb/term_vref_regs_chk.sv ====
// Checker for the termination and reference mode registers
`timescale 1ns/1ps
module term_vref_regs_chk #(
  parameter bit REDUCED_VOLT = 1'b0
) (
  input wire logic clk, // Core clock
  input wire logic rst_n, // Reset
  input wire logic link_clk, // Link clock
  input wire logic cmd_valid, // Strobe
  input wire logic cmd_busy, // Busy
  input wire logic rd_valid, // Read strobe
  input wire logic [15:0] rd_dq, // Read data
  input wire logic calib_pin_to_supply, // Strap
  input wire logic calib_cmd, // Cal command
  input wire logic calib_default_reset, // Cal default
  input wire logic calib_start, // Cal start
  input wire logic calib_use_default, // Default cal
  input wire logic [2:0] data_termination_code, // Data term
  input wire logic [2:0] cmd_termination_code, // Cmd term
  input wire logic [5:0] ca_ref_level_code, // Ref code
  input wire logic ca_ref_range, // Ref range
  input wire logic [9:0] ca_ref_tenths // Level
);
  logic [9:0] exp_tenths;
  logic [15:0] red_steps;
  always_comb begin
    red_steps = (16'(ca_ref_level_code) * 16'h003C + 16'h0005) / 16'h000A;
    if (REDUCED_VOLT) begin
      exp_tenths = (ca_ref_range ? 10'h149 : 10'h096) + red_steps[9:0];
    end else begin
      exp_tenths = (ca_ref_range ? 10'h0DC : 10'h064) + {2'b00, ca_ref_level_code, 2'b00};
    end
  end
  AST_CAL_GND: assert property (@(posedge clk) disable iff (!rst_n)
    !calib_pin_to_supply && $past(rst_n, 4) |-> calib_use_default && !calib_start)
    else $error("grounded strap let calibration act");
  AST_CAL_START: assert property (@(posedge clk) disable iff (!rst_n)
    calib_pin_to_supply && calib_cmd && $past(rst_n, 4) |-> ##[1:2] calib_start)
    else $error("calibration command not started");
  AST_CAL_QUIET: assert property (@(posedge clk) disable iff (!rst_n)
    !$past(calib_cmd) && !$past(calib_cmd, 2) |-> !calib_start)
    else $error("calibration start without command");
  AST_CAL_DEF: assert property (@(posedge clk) disable iff (!rst_n)
    calib_pin_to_supply && calib_default_reset && $past(rst_n, 4) |-> ##[1:2] calib_use_default)
    else $error("default calibration not restored");
  AST_TERM_RSV: assert property (@(posedge clk) disable iff (!rst_n)
    data_termination_code != 3'h7 && cmd_termination_code != 3'h7)
    else $error("reserved termination code active");
  AST_REF_RSV: assert property (@(posedge clk) disable iff (!rst_n)
    ca_ref_level_code <= 6'h32)
    else $error("reserved reference code active");
  AST_RST_VAL: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(rst_n) |-> data_termination_code == 3'h0 && cmd_termination_code == 3'h0 && ca_ref_range
    && ca_ref_level_code == (REDUCED_VOLT ? 6'h1D : 6'h0D))
    else $error("wrong settings out of reset");
  AST_TENTHS: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) && $stable(ca_ref_level_code) && $stable(ca_ref_range) |-> ca_ref_tenths == exp_tenths)
    else $error("level does not match code and range");
  AST_BUSY_ACC: assert property (@(posedge link_clk) disable iff (!rst_n)
    cmd_valid && !cmd_busy |-> ##[1:2] cmd_busy)
    else $error("command not taken");
  AST_BUSY_END: assert property (@(posedge link_clk) disable iff (!rst_n)
    $rose(cmd_busy) |-> ##[2:16] !cmd_busy)
    else $error("command never finished");
  AST_RD_ZERO: assert property (@(posedge link_clk) disable iff (!rst_n)
    rd_valid |-> rd_dq[15:7] == 9'h000 ##1 !rd_valid)
    else $error("read upper lines not zero or strobe too long");
endmodule
bind term_vref_regs term_vref_regs_chk #(.REDUCED_VOLT(REDUCED_VOLT)) chk (
  .clk(clk), .rst_n(rst_n), .link_clk(link_clk), .cmd_valid(cmd_valid), .cmd_busy(cmd_busy),
  .rd_valid(rd_valid), .rd_dq(rd_dq), .calib_pin_to_supply(calib_pin_to_supply), .calib_cmd(calib_cmd),
  .calib_default_reset(calib_default_reset), .calib_start(calib_start), .calib_use_default(calib_use_default),
  .data_termination_code(data_termination_code), .cmd_termination_code(cmd_termination_code),
  .ca_ref_level_code(ca_ref_level_code), .ca_ref_range(ca_ref_range), .ca_ref_tenths(ca_ref_tenths)
);

// ==== tb/term_vref_regs_tb_top.sv ====
// Testbench for the termination and reference mode registers
`timescale 1ns/1ps
module term_vref_regs_tb_top;
  logic clk, rst_n, link_clk, cmd_valid, cmd_write, cmd_busy, rd_valid, tmo;
  logic [5:0] cmd_addr, ca_ref_level_code;
  logic [7:0] cmd_op;
  logic [15:0] rd_dq;
  logic setpoint_access_select, setpoint_active_select, calib_pin_to_supply, calib_cmd, calib_default_reset;
  logic calib_start, calib_use_default, ca_ref_range;
  logic [2:0] data_termination_code, cmd_termination_code;
  logic [9:0] ca_ref_tenths;
  logic [5:0] red_code;
  logic [9:0] red_tenths;
  logic red_range;
  logic [2:0] dt [2];
  logic [2:0] ct [2];
  logic [5:0] rc [2];
  logic rr [2];
  logic [31:0] lfsr;
  int fails, total_checks;

  term_vref_regs #(.REDUCED_VOLT(1'b0)) dut (
    .clk(clk), .rst_n(rst_n), .link_clk(link_clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_addr(cmd_addr), .cmd_op(cmd_op), .cmd_busy(cmd_busy), .rd_valid(rd_valid), .rd_dq(rd_dq),
    .setpoint_access_select(setpoint_access_select), .setpoint_active_select(setpoint_active_select),
    .calib_pin_to_supply(calib_pin_to_supply), .calib_cmd(calib_cmd), .calib_default_reset(calib_default_reset),
    .calib_start(calib_start), .calib_use_default(calib_use_default),
    .data_termination_code(data_termination_code), .cmd_termination_code(cmd_termination_code),
    .ca_ref_level_code(ca_ref_level_code), .ca_ref_range(ca_ref_range), .ca_ref_tenths(ca_ref_tenths)
  );
  term_vref_regs #(.REDUCED_VOLT(1'b1)) dut_red (
    .clk(clk), .rst_n(rst_n), .link_clk(link_clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_addr(cmd_addr), .cmd_op(cmd_op), .cmd_busy(), .rd_valid(), .rd_dq(),
    .setpoint_access_select(setpoint_access_select), .setpoint_active_select(setpoint_active_select),
    .calib_pin_to_supply(calib_pin_to_supply), .calib_cmd(calib_cmd), .calib_default_reset(calib_default_reset),
    .calib_start(), .calib_use_default(), .data_termination_code(), .cmd_termination_code(),
    .ca_ref_level_code(red_code), .ca_ref_range(red_range), .ca_ref_tenths(red_tenths)
  );
  mode_ctrl_model ctrl (
    .link_clk(link_clk), .cmd_busy(cmd_busy), .rd_valid(rd_valid), .rd_dq(rd_dq), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_op(cmd_op), .tmo(tmo)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #13;
    forever #40 link_clk = ~link_clk;
  end

  function automatic logic [31:0] nxt_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] ref_word(input logic s);
    return {9'h000, rr[s], rc[s]};
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (tmo) begin
      fails++;
    end
    $display("checks=%0d errors=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic do_reset(input logic strap);
    @(negedge clk);
    rst_n = 1'b0;
    calib_pin_to_supply = strap;
    for (int s = 0; s < 2; s++) begin
      dt[s] = 3'h0;
      ct[s] = 3'h0;
      rc[s] = 6'h0D;
      rr[s] = 1'b1;
    end
    // Long enough for the link side to see it
    repeat (50) @(negedge clk);
    rst_n = 1'b1;
    repeat (100) @(negedge clk);
    check({red_code, red_tenths}, {6'h1D, 10'h1F7});
    check({15'h0000, red_range}, 16'h0001);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] op, input logic s);
    logic [15:0] d;
    @(negedge clk);
    setpoint_access_select = s;
    ctrl.issue(1'b1, a, op, d);
    if (tmo) begin
      tally_and_finish();
    end
    if (a == 6'h0C) begin
      rc[s] = op[5:0] <= 6'h32 ? op[5:0] : rc[s];
      rr[s] = op[6];
    end
    if (a == 6'h0B) begin
      dt[s] = op[2:0] == 3'h7 ? dt[s] : op[2:0];
      ct[s] = op[6:4] == 3'h7 ? ct[s] : op[6:4];
    end
  endtask
  task automatic rd(input logic [5:0] a, input logic s, input logic [15:0] exp);
    logic [15:0] d;
    @(negedge clk);
    setpoint_access_select = s;
    ctrl.issue(1'b0, a, 8'h00, d);
    if (tmo) begin
      tally_and_finish();
    end
    check(d, exp);
  endtask
  task automatic act(input logic s);
    @(negedge clk);
    setpoint_active_select = s;
    repeat (3) @(negedge clk);
    check({3'h0, data_termination_code, cmd_termination_code, ca_ref_level_code, ca_ref_range},
          {3'h0, dt[s], ct[s], rc[s], rr[s]});
    check({6'h00, ca_ref_tenths}, {6'h00, (rr[s] ? 10'h0DC : 10'h064) + {2'b00, rc[s], 2'b00}});
  endtask
  task automatic cal(input logic c, input logic d, input logic [1:0] exp);
    logic seen;
    @(negedge clk);
    calib_cmd = c;
    calib_default_reset = d;
    @(negedge clk);
    calib_cmd = 1'b0;
    calib_default_reset = 1'b0;
    seen = calib_start;
    @(negedge clk);
    check({14'h0000, seen | calib_start, calib_use_default}, {14'h0000, exp});
  endtask

  initial begin
    rst_n = 1'b0;
    setpoint_access_select = 1'b0;
    setpoint_active_select = 1'b0;
    calib_pin_to_supply = 1'b1;
    calib_cmd = 1'b0;
    calib_default_reset = 1'b0;
    lfsr = 32'h88C3;
    fails = 0;
    total_checks = 0;
    do_reset(1'b1);
    rd(6'h0C, 1'b0, ref_word(1'b0));
    rd(6'h0C, 1'b1, ref_word(1'b1));
    act(1'b0);
    rd(6'h0B, 1'b0, 16'h0000);
    wr(6'h0D, 8'hFF, 1'b0);
    rd(6'h0D, 1'b0, 16'h0000);
    wr(6'h0C, 8'hB3, 1'b0);
    rd(6'h0C, 1'b0, ref_word(1'b0));
    wr(6'h0C, 8'h72, 1'b1);
    rd(6'h0C, 1'b1, ref_word(1'b1));
    act(1'b1);
    for (int k = 0; k < 8; k++) begin
      wr(6'h0B, {1'b1, 3'(k), 1'b1, 3'(7 - k)}, k[0]);
      act(k[0]);
    end
    for (int i = 0; i < 16; i++) begin
      lfsr = nxt_rand(lfsr);
      wr(lfsr[0] ? 6'h0B : 6'h0C, lfsr[15:8], lfsr[16]);
      rd(6'h0C, lfsr[16], ref_word(lfsr[16]));
      act(lfsr[17]);
    end
    cal(1'b1, 1'b0, 2'b10);
    cal(1'b0, 1'b1, 2'b01);
    do_reset(1'b0);
    rd(6'h0C, 1'b1, ref_word(1'b1));
    cal(1'b1, 1'b0, 2'b01);
    cal(1'b0, 1'b1, 2'b01);
    tally_and_finish();
  end
endmodule
